// [include/imst_consts.svh]
// register map, field positions and reset values of the i2c master engine
// assumes byte addresses on the memory-mapped processor port
`ifndef IMST_CONSTS_SVH
`define IMST_CONSTS_SVH

`define IMST_OFS_STATUS 32'hFFFF0884
`define IMST_OFS_RX 32'hFFFF0888
`define IMST_OFS_TX 32'hFFFF088C
`define IMST_OFS_CNT0 32'hFFFF0890
`define IMST_OFS_CNT1 32'hFFFF0894
`define IMST_OFS_ADR0 32'hFFFF0898
`define IMST_OFS_ADR1 32'hFFFF089C
`define IMST_OFS_SBYTE 32'hFFFF08A0
`define IMST_OFS_DIV 32'hFFFF08A4

`define IMST_BYTE_RESET 8'h00
`define IMST_WORD_RESET 16'h0000
`define IMST_DIV_RESET 16'h1F1F

`define IMST_BUSBUSY_BIT 10
`define IMST_BUSY_BIT 6
`define IMST_AL_BIT 5
`define IMST_NA_BIT 4
`define IMST_RXQ_BIT 3
`define IMST_TXQ_BIT 2
`define IMST_LVL_LSB 0

`define IMST_LVL_EMPTY 2'h0
`define IMST_LVL_ONE 2'h1
`define IMST_LVL_MORE 2'h2
`define IMST_LVL_FULL 2'h3

`define IMST_TEN_MARK 5'h1E
`define IMST_CNT_BITS 9
`define IMST_ACK_SLOT 4'h8
`define IMST_RD_FILL 8'hFF

`endif

// [include/imst_pkg.sv]
// types shared by the i2c master engine files
package imst_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_BIT_LO, ST_BIT_HI, ST_RS_LO, ST_RS_HI,
		ST_STOP_LO, ST_STOP_HI, ST_STOP_END
	} imst_state_t;
	typedef enum logic [2:0] {K_SBYTE, K_ADDR1, K_ADDR2, K_WR, K_RD} imst_kind_t;
endpackage

// [src/imst_fifo.sv]
// first-word-fall-through fifo with valid/ready on both sides
// assumes one clock; count output shows current fill level
`timescale 1ns/1ps
`default_nettype none
module imst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("imst_fifo needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW-1:0] nxt_wr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
	wire [AW-1:0] nxt_rd = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

	assign in_ready = (cnt_ff != CW'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign count = cnt_ff;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) wr_ptr_ff <= nxt_wr;
			if (pop) rd_ptr_ff <= nxt_rd;
			if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [src/imst_engine.sv]
// i2c master engine: register file, bit/byte sequencer, tx and rx fifos
// assumes open-drain pads outside; pin inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "imst_consts.svh"
module imst_engine
	import imst_pkg::*;
#(
	parameter int TICK_DIV = 1,
	parameter int TX_DEPTH = 2,
	parameter int RX_DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [31:0] mmr_addr,
	input wire logic mmr_wr,
	input wire logic mmr_rd,
	input wire logic [15:0] mmr_wdata,
	output logic [15:0] mmr_rdata,
	input wire logic master_en,
	input wire logic arb_lost_irq_enable,
	input wire logic nack_irq_enable,
	input wire logic rx_irq_enable,
	input wire logic tx_irq_enable,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	localparam int TCW = TICK_DIV > 1 ? $clog2(TICK_DIV) : 1;
	localparam int TXC = $clog2(TX_DEPTH + 1);
	localparam int RXC = $clog2(RX_DEPTH + 1);

	if (TICK_DIV < 1 || TX_DEPTH < 2 || RX_DEPTH < 2) begin : g_chk
		$error("imst_engine needs TICK_DIV >= 1 and fifo depths >= 2");
	end

	// register file
	logic [7:0] tx_byte_ff, adr0_ff, adr1_ff, sbyte_ff;
	logic [15:0] rdcnt_ff, div_ff, mmr_rdata_ff;
	logic sbyte_pend_ff, go_ff;

	// sequencer state
	imst_state_t state_ff, nxt_state;
	imst_kind_t kind_ff, nxt_kind;
	logic [7:0] tmr_ff, nxt_tmr;
	logic [3:0] bit_ff, nxt_bit;
	logic [8:0] sh_ff, nxt_sh;
	logic [7:0] rxsh_ff, nxt_rxsh;
	logic [8:0] rcv_ff;
	logic [TCW-1:0] pre_ff;
	logic al_ff, na_ff, wr_phase_ff, bus_busy_ff, sda_q_ff, scl_q_ff;
	logic scl_oe_ff, sda_oe_ff, nxt_scl_oe, nxt_sda_oe;
	logic set_al, set_na, set_wr_phase, start_take, tx_pop, rx_push;

	// fifo wiring
	logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
	logic [7:0] tx_out_data, rx_out_data;
	logic [TXC-1:0] tx_count;
	logic [RXC-1:0] rx_count;

	wire wr_sel_tx = mmr_wr && (mmr_addr == `IMST_OFS_TX);
	wire wr_sel_cnt0 = mmr_wr && (mmr_addr == `IMST_OFS_CNT0);
	wire wr_sel_adr0 = mmr_wr && (mmr_addr == `IMST_OFS_ADR0);
	wire wr_sel_adr1 = mmr_wr && (mmr_addr == `IMST_OFS_ADR1);
	wire wr_sel_sbyte = mmr_wr && (mmr_addr == `IMST_OFS_SBYTE);
	wire wr_sel_div = mmr_wr && (mmr_addr == `IMST_OFS_DIV);
	wire rd_sel_rx = mmr_rd && (mmr_addr == `IMST_OFS_RX);

	wire tick = (pre_ff == '0);
	wire tdone = tick && (tmr_ff == '0);
	wire [7:0] scl_high_count = div_ff[15:8];
	wire [7:0] scl_low_count = div_ff[7:0];
	wire ten_bit = (adr0_ff[7:3] == `IMST_TEN_MARK);
	wire dir_rd = adr0_ff[0];
	wire ack_slot = (bit_ff == `IMST_ACK_SLOT);
	wire rd_ack_slot = (kind_ff == K_RD) && ack_slot;
	// only bits that we send are checked; the ack slot of a write belongs to the slave
	wire arb_check = (kind_ff != K_RD) && !ack_slot;
	wire arb_fail = arb_check && sh_ff[8] && !sda_in;
	wire last_rd = (rcv_ff == rdcnt_ff[`IMST_CNT_BITS-1:0]);
	wire bus_start = scl_q_ff && scl_in && sda_q_ff && !sda_in;
	wire bus_stop = scl_q_ff && scl_in && !sda_q_ff && sda_in;

	wire busy = (state_ff != ST_IDLE);
	wire txq = wr_phase_ff && (tx_count <= TXC'(1));
	wire rxq = rx_out_valid;
	wire [1:0] tx_lvl = (tx_count == '0) ? `IMST_LVL_EMPTY :
		(tx_count == TXC'(1)) ? `IMST_LVL_ONE :
		(tx_count == TXC'(TX_DEPTH)) ? `IMST_LVL_FULL : `IMST_LVL_MORE;

	logic [15:0] status;
	always_comb begin
		status = `IMST_WORD_RESET;
		status[`IMST_BUSBUSY_BIT] = bus_busy_ff;
		status[`IMST_BUSY_BIT] = busy;
		status[`IMST_AL_BIT] = al_ff;
		status[`IMST_NA_BIT] = na_ff;
		status[`IMST_RXQ_BIT] = rxq;
		status[`IMST_TXQ_BIT] = txq;
		status[`IMST_LVL_LSB+1:`IMST_LVL_LSB] = tx_lvl;
	end

	wire [15:0] rd_mux =
		(mmr_addr == `IMST_OFS_STATUS) ? status :
		(mmr_addr == `IMST_OFS_RX) ? {8'h00, rx_out_valid ? rx_out_data : `IMST_BYTE_RESET} :
		(mmr_addr == `IMST_OFS_TX) ? {8'h00, tx_byte_ff} :
		(mmr_addr == `IMST_OFS_CNT0) ? rdcnt_ff :
		(mmr_addr == `IMST_OFS_CNT1) ? {8'h00, rcv_ff[7:0]} :
		(mmr_addr == `IMST_OFS_ADR0) ? {8'h00, adr0_ff} :
		(mmr_addr == `IMST_OFS_ADR1) ? {8'h00, adr1_ff} :
		(mmr_addr == `IMST_OFS_SBYTE) ? {8'h00, sbyte_ff} :
		(mmr_addr == `IMST_OFS_DIV) ? div_ff : `IMST_WORD_RESET;

	assign irq = (al_ff && arb_lost_irq_enable) || (na_ff && nack_irq_enable) ||
		(rxq && rx_irq_enable) || (txq && tx_irq_enable);
	assign mmr_rdata = mmr_rdata_ff;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_ff;
	assign sda_oe = sda_oe_ff;

	imst_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(wr_sel_tx),
		.in_ready(tx_in_ready),
		.in_data(mmr_wdata[7:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data),
		.count(tx_count)
	);

	// a full rx fifo stalls the ack slot, which stretches scl low
	imst_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data(rxsh_ff),
		.out_valid(rx_out_valid),
		.out_ready(rd_sel_rx),
		.out_data(rx_out_data),
		.count(rx_count)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_tmr = (tick && tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_rxsh = rxsh_ff;
		set_al = 1'b0;
		set_na = 1'b0;
		set_wr_phase = 1'b0;
		start_take = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				// wait for a free bus; another master's frame keeps us idle, not busy
				if (go_ff && !bus_busy_ff && scl_in && sda_in) begin
					nxt_state = ST_START;
					nxt_tmr = scl_high_count;
					start_take = 1'b1;
				end
			end
			ST_START: begin
				if (tdone) begin
					nxt_state = ST_BIT_LO;
					nxt_tmr = scl_low_count;
					nxt_bit = '0;
					nxt_kind = sbyte_pend_ff ? K_SBYTE : K_ADDR1;
					nxt_sh = {sbyte_pend_ff ? sbyte_ff : adr0_ff, 1'b1};
				end
			end
			ST_BIT_LO: begin
				if (tdone && !(rd_ack_slot && !rx_in_ready)) begin
					nxt_state = ST_BIT_HI;
					nxt_tmr = scl_high_count;
					rx_push = rd_ack_slot;
				end
			end
			ST_BIT_HI: begin
				if (!scl_in) begin
					nxt_tmr = tmr_ff;
				end else if (tdone) begin
					nxt_state = ST_BIT_LO;
					nxt_tmr = scl_low_count;
					if (arb_fail) begin
						set_al = 1'b1;
						nxt_state = ST_IDLE;
					end else if (!ack_slot) begin
						nxt_bit = bit_ff + 1'b1;
						nxt_sh = {sh_ff[7:0], 1'b1};
						nxt_rxsh = {rxsh_ff[6:0], sda_in};
					end else begin
						nxt_bit = '0;
						case (kind_ff)
							K_SBYTE: nxt_state = ST_RS_LO;
							K_ADDR1, K_ADDR2: begin
								if (sda_in) begin
									set_na = 1'b1;
									nxt_state = ST_STOP_LO;
								end else if (kind_ff == K_ADDR1 && ten_bit) begin
									nxt_kind = K_ADDR2;
									nxt_sh = {adr1_ff, 1'b1};
								end else if (dir_rd) begin
									nxt_kind = K_RD;
									nxt_sh = {`IMST_RD_FILL, last_rd};
								end else begin
									set_wr_phase = 1'b1;
									nxt_kind = K_WR;
									nxt_sh = {tx_out_data, 1'b1};
									tx_pop = tx_out_valid;
									if (!tx_out_valid) nxt_state = ST_STOP_LO;
								end
							end
							K_WR: begin
								// an empty tx fifo at a byte boundary ends the write
								nxt_sh = {tx_out_data, 1'b1};
								tx_pop = tx_out_valid && !sda_in;
								if (sda_in || !tx_out_valid) nxt_state = ST_STOP_LO;
							end
							K_RD: begin
								nxt_sh = {`IMST_RD_FILL, last_rd};
								if (sh_ff[8]) nxt_state = ST_STOP_LO;
							end
							default: nxt_state = ST_STOP_LO;
						endcase
					end
				end
			end
			ST_RS_LO: begin
				if (tdone) begin
					nxt_state = ST_RS_HI;
					nxt_tmr = scl_high_count;
				end
			end
			ST_RS_HI: begin
				if (!scl_in) nxt_tmr = tmr_ff;
				else if (tdone) begin
					nxt_state = ST_START;
					nxt_tmr = scl_high_count;
				end
			end
			ST_STOP_LO: begin
				if (tdone) begin
					nxt_state = ST_STOP_HI;
					nxt_tmr = scl_high_count;
				end
			end
			ST_STOP_HI: begin
				if (!scl_in) nxt_tmr = tmr_ff;
				else if (tdone) begin
					nxt_state = ST_STOP_END;
					nxt_tmr = scl_high_count;
				end
			end
			ST_STOP_END: begin
				if (tdone) nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_comb begin
		nxt_scl_oe = (nxt_state == ST_BIT_LO) || (nxt_state == ST_RS_LO) || (nxt_state == ST_STOP_LO);
		case (nxt_state)
			ST_START, ST_STOP_LO, ST_STOP_HI: nxt_sda_oe = 1'b1;
			ST_BIT_LO, ST_BIT_HI: nxt_sda_oe = !nxt_sh[8];
			default: nxt_sda_oe = 1'b0;
		endcase
		// sda moves one cycle after scl falls so no false start or stop appears
		if (nxt_scl_oe && !scl_oe_ff) nxt_sda_oe = sda_oe_ff;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
			kind_ff <= K_ADDR1;
			tmr_ff <= `IMST_BYTE_RESET;
			bit_ff <= '0;
			sh_ff <= '1;
			rxsh_ff <= `IMST_BYTE_RESET;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			tmr_ff <= nxt_tmr;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			rxsh_ff <= nxt_rxsh;
			scl_oe_ff <= nxt_scl_oe;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_ff <= '0;
			sda_q_ff <= 1'b1;
			scl_q_ff <= 1'b1;
			bus_busy_ff <= 1'b0;
		end else begin
			pre_ff <= (pre_ff == TCW'(TICK_DIV - 1)) ? '0 : pre_ff + 1'b1;
			sda_q_ff <= sda_in;
			scl_q_ff <= scl_in;
			if (bus_start) bus_busy_ff <= 1'b1;
			else if (bus_stop) bus_busy_ff <= 1'b0;
		end
	end

	// status flags: a set in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			al_ff <= 1'b0;
			na_ff <= 1'b0;
			wr_phase_ff <= 1'b0;
			rcv_ff <= '0;
		end else begin
			al_ff <= set_al || (al_ff && !start_take);
			na_ff <= set_na || (na_ff && !start_take);
			wr_phase_ff <= set_wr_phase || (wr_phase_ff && state_ff != ST_IDLE);
			if (start_take) rcv_ff <= '0;
			else if (rx_push && rx_in_ready) rcv_ff <= rcv_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_byte_ff <= `IMST_BYTE_RESET;
			rdcnt_ff <= `IMST_WORD_RESET;
			adr0_ff <= `IMST_BYTE_RESET;
			adr1_ff <= `IMST_BYTE_RESET;
			sbyte_ff <= `IMST_BYTE_RESET;
			div_ff <= `IMST_DIV_RESET;
			mmr_rdata_ff <= `IMST_WORD_RESET;
		end else begin
			if (wr_sel_tx) tx_byte_ff <= mmr_wdata[7:0];
			if (wr_sel_cnt0) rdcnt_ff <= mmr_wdata;
			if (wr_sel_adr0) adr0_ff <= mmr_wdata[7:0];
			if (wr_sel_adr1) adr1_ff <= mmr_wdata[7:0];
			if (wr_sel_sbyte) sbyte_ff <= mmr_wdata[7:0];
			if (wr_sel_div) div_ff <= mmr_wdata;
			if (mmr_rd) mmr_rdata_ff <= rd_mux;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			go_ff <= 1'b0;
			sbyte_pend_ff <= 1'b0;
		end else begin
			go_ff <= (wr_sel_adr0 && master_en) || (go_ff && master_en && !start_take);
			if (wr_sel_sbyte) sbyte_pend_ff <= 1'b1;
			else if (state_ff == ST_START && tdone) sbyte_pend_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [verification/imst_engine_props.sv]
// port assertions for the i2c master engine
// assumes a bind onto imst_engine; one clock domain
`timescale 1ns/1ps
`default_nettype none
module imst_engine_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [31:0] mmr_addr,
	input wire logic mmr_wr,
	input wire logic mmr_rd,
	input wire logic [15:0] mmr_rdata,
	input wire logic master_en,
	input wire logic arb_lost_irq_enable,
	input wire logic nack_irq_enable,
	input wire logic rx_irq_enable,
	input wire logic tx_irq_enable,
	input wire logic irq,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire st_rd = mmr_rd && mmr_addr == 32'hFFFF0884;
	wire byte_rd = mmr_rd && mmr_addr[31:8] == 24'hFFFF08 && mmr_addr[7:0] inside {8'h88, 8'h8C, 8'h94, 8'h98, 8'h9C, 8'hA0};
	wire gated = mmr_wr && mmr_addr == 32'hFFFF0898 && !master_en && !sda_oe && !scl_oe;
	wire any_en = arb_lost_irq_enable || nack_irq_enable || rx_irq_enable || tx_irq_enable;
	sequence s_start;
		$rose(sda_oe) && !scl_oe;
	endsequence
	sequence s_stop;
		$fell(sda_oe) && !scl_oe;
	endsequence
	property p_open_drain;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pad data not low");
	property p_start;
		s_start |-> scl_in ##1 sda_oe;
	endproperty
	a_start: assert property (p_start) else $error("start not made with scl high");
	property p_stop;
		s_stop |-> scl_in;
	endproperty
	a_stop: assert property (p_stop) else $error("sda released high while scl low");
	property p_gated;
		gated |=> !sda_oe [*3];
	endproperty
	a_gated: assert property (p_gated) else $error("start while master disabled");
	property p_scl_low;
		$rose(scl_oe) |-> scl_oe [*2];
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
	property p_busy;
		st_rd && (scl_oe || sda_oe) |=> mmr_rdata[6];
	endproperty
	a_busy: assert property (p_busy) else $error("busy low while driving bus");
	property p_rsvd;
		st_rd |=> mmr_rdata[15:11] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
	property p_bytes;
		byte_rd |=> mmr_rdata[15:8] == 8'h00;
	endproperty
	a_bytes: assert property (p_bytes) else $error("byte register upper bits set");
	property p_hold;
		!mmr_rd |=> $stable(mmr_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_irq;
		irq |-> any_en;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enable");
endmodule
bind imst_engine imst_engine_props u_props (.clk(clk), .rst_b(rst_b), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr),
	.mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata), .master_en(master_en), .arb_lost_irq_enable(arb_lost_irq_enable),
	.nack_irq_enable(nack_irq_enable), .rx_irq_enable(rx_irq_enable), .tx_irq_enable(tx_irq_enable), .irq(irq),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// [verification/imst_slave.sv]
// behavioural i2c slave: logs bytes, acks on request, answers reads
// assumes open-drain wires with pull-ups, sampled on clk
`timescale 1ns/1ps
`default_nettype none
module imst_slave #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	input wire logic [7:0] rd_base,
	input wire logic [7:0] hold,
	output logic scl_oe,
	output logic sda_oe
);
	logic scl_q = 1'b1, sda_q = 1'b1, act = 1'b0, rd = 1'b0, rd_nxt = 1'b0, first = 1'b0;
	logic [3:0] bitn = 4'h0;
	logic [7:0] sh = 8'h00, txb = 8'h00, hcnt = 8'h00, nlog = 8'h00;
	logic [7:0] log_q [16];
	int macks = 0;
	initial scl_oe = 1'b0;
	initial sda_oe = 1'b0;
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		scl_oe <= hcnt != 8'h00;
		if (hcnt != 8'h00) hcnt <= hcnt - 8'h01;
		if (scl && scl_q && sda_q && !sda) begin
			act <= 1'b1;
			bitn <= 4'h0;
			first <= 1'b1;
			rd <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && scl_q && !sda_q && sda) begin
			act <= 1'b0;
			rd <= 1'b0;
		end else if (act && scl && !scl_q) begin
			if (bitn != 4'h8) begin
				sh <= {sh[6:0], sda};
				bitn <= bitn + 4'h1;
			end else begin
				bitn <= 4'h0;
				first <= 1'b0;
				if (rd && !sda) macks <= macks + 1;
				if (rd && !sda) txb <= txb + 8'h01;
				rd <= rd ? !sda : rd_nxt;
			end
		end else if (act && !scl && scl_q) begin
			if (bitn == 4'h8 && !rd) begin
				// ack slot: log, ack and stretch scl when asked to be slow
				sda_oe <= ack_en;
				log_q[nlog[3:0]] <= sh;
				nlog <= nlog + 8'h01;
				rd_nxt <= first && ack_en && sh == {ADDR, 1'b1};
				txb <= rd_base;
				hcnt <= hold;
			end else if (rd) begin
				sda_oe <= bitn == 4'h8 ? 1'b0 : !txb[3'h7 - bitn[2:0]];
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the i2c master engine with a slave model
// assumes pull-ups on both bus wires, resolved here
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e;} imst_row_t;
	localparam imst_row_t ROWS [15] = '{'{8'hA4, 1'b0, 16'h0, 16'h1F1F}, '{8'h84, 1'b0, 16'h0, 16'h0},
		'{8'h88, 1'b0, 16'h0, 16'h0}, '{8'h8C, 1'b0, 16'h0, 16'h0}, '{8'h90, 1'b0, 16'h0, 16'h0},
		'{8'h94, 1'b0, 16'h0, 16'h0}, '{8'h98, 1'b0, 16'h0, 16'h0}, '{8'h9C, 1'b0, 16'h0, 16'h0},
		'{8'hA0, 1'b0, 16'h0, 16'h0}, '{8'h90, 1'b1, 16'h01FF, 16'h01FF}, '{8'h94, 1'b1, 16'h55, 16'h0},
		'{8'h88, 1'b1, 16'h55, 16'h0}, '{8'hA4, 1'b1, 16'h0302, 16'h0302}, '{8'hA8, 1'b1, 16'h1234, 16'h0},
		'{8'h9C, 1'b1, 16'h5A, 16'h5A}};
	logic clk = 1'b0, rst_b = 1'b0, mmr_wr = 1'b0, mmr_rd = 1'b0, master_en = 1'b1, pull = 1'b0;
	logic ack_en = 1'b1, irq_seen = 1'b0;
	logic [31:0] mmr_addr = 32'h0;
	logic [15:0] mmr_wdata = 16'h0, v = 16'h0, seen = 16'h0;
	logic [3:0] ien = 4'h0;
	logic [7:0] hold = 8'h00, n0;
	logic [15:0] mmr_rdata;
	wire logic irq, scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe;
	wire logic scl = !(scl_oe || s_scl_oe);
	wire logic sda = !(sda_oe || s_sda_oe || pull);
	int fails = 0, total_checks = 0;
	imst_engine dut (.clk(clk), .rst_b(rst_b), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
		.mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata), .master_en(master_en), .arb_lost_irq_enable(ien[3]),
		.nack_irq_enable(ien[2]), .rx_irq_enable(ien[1]), .tx_irq_enable(ien[0]), .irq(irq), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	imst_slave slv (.clk(clk), .scl(scl), .sda(sda), .ack_en(ack_en), .rd_base(8'h70), .hold(hold),
		.scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
	initial forever #2 clk = ~clk;
	task automatic finish_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// strobes drop a cycle before the next access so no edge sees two writes of them
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		mmr_addr = {24'hFFFF08, a};
		mmr_wdata = d;
		mmr_wr = 1'b1;
		@(negedge clk);
		mmr_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		mmr_addr = {24'hFFFF08, a};
		mmr_rd = 1'b1;
		@(negedge clk);
		mmr_rd = 1'b0;
		v = mmr_rdata;
		@(negedge clk);
	endtask
	// the start is launched at the edge after the one that takes the address write
	task automatic go(input logic [7:0] a);
		mmr_addr = {24'hFFFF08, 8'h98};
		mmr_wdata = {8'h00, a};
		mmr_wr = 1'b1;
		@(negedge clk);
		mmr_wr = 1'b0;
		chk("start early", 16'(sda_oe), 16'h0);
		@(negedge clk);
		chk("start", 16'(sda_oe), 16'h1);
	endtask
	task automatic wait_idle();
		seen = 16'h0;
		irq_seen = 1'b0;
		for (int i = 0; i < 3000; i++) begin
			rd(8'h84);
			seen = seen | v;
			irq_seen = irq_seen | irq;
			if (v[6] === 1'b0 && v[10] === 1'b0) return;
		end
		fails++;
		finish_test();
	endtask
	task automatic wait_scl();
		for (int i = 0; i < 300; i++) begin
			if (scl_oe === 1'b1) return;
			@(negedge clk);
		end
		fails++;
		finish_test();
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		foreach (ROWS[i]) begin
			if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
			rd(ROWS[i].a);
			chk($sformatf("reg %0d", i), v, ROWS[i].e);
		end
		master_en = 1'b0;
		wr(8'h98, 16'hA0);
		chk("gated start", 16'(sda_oe), 16'h0);
		master_en = 1'b1;
		ien = 4'h1;
		wr(8'h8C, 16'h3C);
		rd(8'h84);
		chk("level one", 16'(v[1:0]), 16'h1);
		wr(8'h8C, 16'hA5);
		rd(8'h84);
		chk("level full", 16'(v[1:0]), 16'h3);
		wr(8'h8C, 16'h77);
		go(8'hA0);
		wait_idle();
		chk("busy seen", 16'(seen[6]), 16'h1);
		chk("tx request", {15'h0, seen[2]}, 16'h1);
		chk("tx irq", 16'(irq_seen), 16'h1);
		chk("flags clear", 16'(seen[5:4]), 16'h0);
		chk("write bytes", {slv.log_q[0], slv.log_q[1]}, 16'hA03C);
		chk("last byte", {slv.log_q[2], slv.nlog}, 16'hA503);
		ien = 4'h2;
		hold = 8'h06;
		wr(8'h90, 16'h0002);
		go(8'hA1);
		wait_idle();
		chk("rx request", 16'(v[3]), 16'h1);
		chk("rx irq", 16'(irq), 16'h1);
		chk("master acks", 16'(slv.macks), 16'h2);
		rd(8'h94);
		chk("bytes counted", v, 16'h3);
		for (int i = 0; i < 3; i++) begin
			rd(8'h88);
			chk("rx byte", v, 16'h70 + 16'(i));
		end
		rd(8'h84);
		chk("rx drained", 16'({v[3], 7'h0, irq}), 16'h0);
		ack_en = 1'b0;
		ien = 4'h4;
		go(8'hA0);
		wait_idle();
		chk("addr nack", 16'({v[4], 7'h0, irq}), 16'h0101);
		ien = 4'h0;
		@(negedge clk);
		chk("irq masked", 16'(irq), 16'h0);
		ack_en = 1'b1;
		n0 = slv.nlog;
		wr(8'hA0, 16'h99);
		wr(8'h8C, 16'h11);
		go(8'hF4);
		wait_idle();
		chk("nack cleared", 16'(v[4]), 16'h0);
		chk("lead then addr", {slv.log_q[n0[3:0]], slv.log_q[n0[3:0] + 4'h1]}, 16'h99F4);
		chk("low addr", {slv.log_q[n0[3:0] + 4'h2], slv.log_q[n0[3:0] + 4'h3]}, 16'h5A11);
		ien = 4'h8;
		go(8'hA0);
		wait_scl();
		// a rival master holds sda low while the first address bit is a one
		pull = 1'b1;
		for (int i = 0; i < 100 && v[5] !== 1'b1; i++) rd(8'h84);
		chk("arb lost", 16'({v[5], 7'h0, irq}), 16'h0101);
		chk("busy after loss", 16'(v[6]), 16'h0);
		pull = 1'b0;
		wait_idle();
		go(8'hA0);
		wait_scl();
		rst_b = 1'b0;
		@(negedge clk);
		chk("reset pads", 16'({scl_oe, sda_oe, irq}), 16'h0);
		rst_b = 1'b1;
		rd(8'hA4);
		chk("divider reset", v, 16'h1F1F);
		finish_test();
	end
endmodule
`default_nettype wire
